// *** icrp_regs.svh ***
// constants for the two-wire configuration register port
`ifndef ICRP_REGS_SVH
`define ICRP_REGS_SVH
`define ICRP_SLV_HI    4'hd
`define ICRP_OP_WR     3'h3
`define ICRP_OP_RD     3'h4
`define ICRP_NPORT     5'h06
`define ICRP_LAST_IDX  2'h3
`define ICRP_BIT_ACK   4'h8
`define ICRP_BIT_END   4'h9
`define ICRP_REG_DEPTH 1024
`define ICRP_CLK_NS    5
`define ICRP_SCL_NS    160
`define ICRP_QTR_CYC   (`ICRP_SCL_NS / (4 * `ICRP_CLK_NS))
`define ICRP_B_ADRW    4'h0
`define ICRP_B_CMD0    4'h1
`define ICRP_B_CMD1    4'h2
`define ICRP_B_CMD2    4'h3
`define ICRP_B_CMD3    4'h4
`define ICRP_B_D3      4'h5
`define ICRP_B_D2      4'h6
`define ICRP_B_D1      4'h7
`define ICRP_B_D0      4'h8
`define ICRP_B_R0      4'h9
`endif

// *** icrp_pkg.sv ***
// types shared by both ends of the register port
`default_nettype none
package icrp_pkg;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ADDR = 3'b001,
      PH_CMD  = 3'b010,
      PH_WDAT = 3'b011,
      PH_TX   = 3'b100,
      PH_SKIP = 3'b101
   } icrp_phase_t;
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_START = 2'b01,
      H_BIT   = 2'b10,
      H_STOP  = 2'b11
   } icrp_hstate_t;
endpackage : icrp_pkg
`default_nettype wire

// *** icrp_if.sv ***
// open-drain two-wire link joining host and device
`timescale 1ns/1ps
`default_nettype none
interface icrp_if;
   logic scl_h_o;
   logic scl_h_oe_n;
   logic sda_h_o;
   logic sda_h_oe_n;
   logic sda_d_o;
   logic sda_d_oe_n;
   logic scl;
   logic sda;
   // wired-and of the open-drain drivers
   assign scl = scl_h_oe_n | scl_h_o;
   assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
   modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe_n);
   modport host (input sda, output scl_h_o, output scl_h_oe_n, output sda_h_o,
                 output sda_h_oe_n);
endinterface : icrp_if
`default_nettype wire

// *** icrp_host.sv ***
// bus master end: runs one register write or read per go pulse
`timescale 1ns/1ps
`default_nettype none
`include "icrp_regs.svh"
module icrp_host (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   icrp_if.host            bus,
   input  wire logic [2:0] dev_strap,
   input  wire logic       go,
   input  wire logic       rd,
   input  wire logic       merged,
   input  wire logic [2:0] opcode,
   input  wire logic [4:0] port_sel,
   input  wire logic [9:0] dw_addr,
   input  wire logic [3:0] byte_en,
   input  wire logic [31:0] wdata,
   output logic            busy,
   output logic            done,
   output logic            nack_err,
   output logic [31:0]     rdata
);
   icrp_pkg::icrp_hstate_t st_reg;
   logic [3:0]  tick_cnt_reg;
   logic        tick;
   logic [1:0]  q_reg;
   logic [3:0]  hb_reg;
   logic [3:0]  bidx_reg;
   logic        rd_reg;
   logic        merged_reg;
   logic        again_reg;
   logic        nack_reg;
   logic [2:0]  op_reg;
   logic [4:0]  port_reg;
   logic [9:0]  adr_reg;
   logic [3:0]  be_reg;
   logic [31:0] wd_reg;
   logic        sda_s1;
   logic        sda_s2;
   logic [6:0]  slv;
   logic [7:0]  tbyte;
   logic        rx;

   assign slv  = {`ICRP_SLV_HI, dev_strap};
   assign tick = (tick_cnt_reg == 4'(`ICRP_QTR_CYC - 1));
   assign rx   = rd_reg && (bidx_reg >= `ICRP_B_D2);
   assign bus.scl_h_o = 1'b0;
   assign bus.sda_h_o = 1'b0;

   // (R2) (R3) (R4) (R7) (R8) (R9) (R10) byte order and command layout
   always_comb begin
      case (bidx_reg)
         `ICRP_B_ADRW: tbyte = {slv, 1'b0};
         `ICRP_B_CMD0: tbyte = {5'h00, op_reg};
         `ICRP_B_CMD1: tbyte = {4'h0, port_reg[4:1]};
         `ICRP_B_CMD2: tbyte = {port_reg[0], 1'b0, be_reg, adr_reg[9:8]};
         `ICRP_B_CMD3: tbyte = adr_reg[7:0];
         `ICRP_B_D3:   tbyte = rd_reg ? {slv, 1'b1} : wd_reg[31:24];
         `ICRP_B_D2:   tbyte = wd_reg[23:16];
         `ICRP_B_D1:   tbyte = wd_reg[15:8];
         `ICRP_B_D0:   tbyte = wd_reg[7:0];
         default:      tbyte = 8'hff;
      endcase
   end

   // quarter-bit divider
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_reg <= 4'h0;
      end else begin
         tick_cnt_reg <= tick ? 4'h0 : tick_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end else begin
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg         <= icrp_pkg::H_IDLE;
         q_reg          <= 2'h0;
         hb_reg         <= 4'h0;
         bidx_reg       <= 4'h0;
         rd_reg         <= 1'b0;
         merged_reg     <= 1'b0;
         again_reg      <= 1'b0;
         nack_reg       <= 1'b0;
         op_reg         <= 3'h0;
         port_reg       <= 5'h00;
         adr_reg        <= 10'h000;
         be_reg         <= 4'h0;
         wd_reg         <= 32'h0000_0000;
         busy           <= 1'b0;
         done           <= 1'b0;
         nack_err       <= 1'b0;
         rdata          <= 32'h0000_0000;
         bus.scl_h_oe_n <= 1'b1;
         bus.sda_h_oe_n <= 1'b1;
      end else begin
         done <= 1'b0;
         if (st_reg == icrp_pkg::H_IDLE) begin
            if (go) begin
               st_reg     <= icrp_pkg::H_START;
               q_reg      <= 2'h0;
               bidx_reg   <= `ICRP_B_ADRW;
               rd_reg     <= rd;
               merged_reg <= merged;
               op_reg     <= opcode;
               port_reg   <= port_sel;
               adr_reg    <= dw_addr;
               be_reg     <= byte_en;
               wd_reg     <= wdata;
               nack_reg   <= 1'b0;
               busy       <= 1'b1;
            end
         end else if (tick) begin
            q_reg <= q_reg + 2'h1;
            case (st_reg)
               // (R1) (R15) start or repeated start framing
               icrp_pkg::H_START: begin
                  case (q_reg)
                     2'h0: bus.sda_h_oe_n <= 1'b1;
                     2'h1: bus.scl_h_oe_n <= 1'b1;
                     2'h2: bus.sda_h_oe_n <= 1'b0;
                     default: begin
                        bus.scl_h_oe_n <= 1'b0;
                        st_reg         <= icrp_pkg::H_BIT;
                        hb_reg         <= 4'h0;
                     end
                  endcase
               end
               icrp_pkg::H_BIT: begin
                  case (q_reg)
                     2'h0: begin
                        if (hb_reg != `ICRP_BIT_ACK) begin
                           bus.sda_h_oe_n <= rx | tbyte[3'h7 - hb_reg[2:0]];
                        end else begin
                           // last read byte answered with a release
                           bus.sda_h_oe_n <= !rx || (bidx_reg == `ICRP_B_R0);
                        end
                     end
                     2'h1: bus.scl_h_oe_n <= 1'b1;
                     2'h2: begin
                        if (hb_reg != `ICRP_BIT_ACK) begin
                           if (rx) begin
                              rdata <= {rdata[30:0], sda_s2};
                           end
                        end else if (!rx && sda_s2) begin
                           nack_reg <= 1'b1;
                        end
                     end
                     default: begin
                        bus.scl_h_oe_n <= 1'b0;
                        hb_reg         <= hb_reg + 4'h1;
                        if (hb_reg == `ICRP_BIT_ACK) begin
                           hb_reg   <= 4'h0;
                           bidx_reg <= bidx_reg + 4'h1;
                           // (R17) four data bytes only
                           if (nack_reg || bidx_reg == `ICRP_B_R0 ||
                               (!rd_reg && bidx_reg == `ICRP_B_D0)) begin
                              st_reg <= icrp_pkg::H_STOP;
                           end else if (rd_reg && bidx_reg == `ICRP_B_CMD3) begin
                              // (R15) merged read uses repeated start
                              st_reg    <= merged_reg ? icrp_pkg::H_START
                                                      : icrp_pkg::H_STOP;
                              again_reg <= !merged_reg;
                           end
                        end
                     end
                  endcase
               end
               icrp_pkg::H_STOP: begin
                  case (q_reg)
                     2'h0: bus.sda_h_oe_n <= 1'b0;
                     2'h1: bus.scl_h_oe_n <= 1'b1;
                     2'h2: bus.sda_h_oe_n <= 1'b1;
                     default: begin
                        if (again_reg && !nack_reg) begin
                           again_reg <= 1'b0;
                           st_reg    <= icrp_pkg::H_START;
                        end else begin
                           again_reg <= 1'b0;
                           st_reg    <= icrp_pkg::H_IDLE;
                           busy      <= 1'b0;
                           done      <= 1'b1;
                           nack_err  <= nack_reg;
                        end
                     end
                  endcase
               end
               default: st_reg <= icrp_pkg::H_IDLE;
            endcase
         end
      end
   end
endmodule : icrp_host
`default_nettype wire

// *** icrp_dev.sv ***
// device end: two-wire slave giving access to per-port 32-bit registers
`timescale 1ns/1ps
`default_nettype none
`include "icrp_regs.svh"
//
// Contract
// (R1) address 68h with straps low; start/stop framing
// (R2) write opcode 011b in command byte 0
// (R3) read opcode 100b in command byte 0
// (R4) port select from byte1[3:0], byte2[7]
// (R5) port select 0..5 picks port space
// (R6) byte2[5:2] enables register bytes on write
// (R7) dword address byte2[1:0], byte3; low bits zero
// (R8) write data most significant byte first
// (R9) read starts with write address, command bytes
// (R10) second address byte with read bit set
// (R11) address bit 0 set means read
// (R12) read command fetches register into buffer
// (R13) read data most significant byte first
// (R14) reading past four bytes repeats buffer
// (R15) repeated start joins command and read
// (R16) invalid opcode leaves register unchanged
// (R17) master always sends four write bytes
// (R18) extra write bytes get not-acknowledge
// (R19) ack address, commands, four data; commit after
// (R20) ignore reserved bits and foreign addresses
module icrp_dev (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   icrp_if.dev              bus,
   input  wire logic [2:0]  addr_strap,
   input  wire logic        load_stb,
   input  wire logic [2:0]  load_port,
   input  wire logic [9:0]  load_addr,
   input  wire logic [31:0] load_data,
   input  wire logic [2:0]  peek_port,
   input  wire logic [9:0]  peek_addr,
   output logic [31:0]      peek_data,
   output logic             upd_stb,
   output logic [4:0]       upd_port,
   output logic [9:0]       upd_addr
);
   logic [31:0] mem [0:`ICRP_NPORT-1][0:`ICRP_REG_DEPTH-1];
   icrp_pkg::icrp_phase_t phase_reg;
   logic [7:0]  cmd_reg [0:3];
   logic [7:0]  sh_reg;
   logic [3:0]  cnt_reg;
   logic [1:0]  idx_reg;
   logic        wfull_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rbuf_reg;
   logic        fetch_pend_reg;
   logic        commit_pend_reg;
   logic [6:0]  slv_reg;
   logic [2:0]  strap_s1;
   logic [2:0]  strap_s2;
   logic        scl_s1;
   logic        scl_s2;
   logic        scl_d;
   logic        sda_s1;
   logic        sda_s2;
   logic        sda_d;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic [4:0]  port;
   logic [9:0]  dw_addr;
   logic [3:0]  be;
   logic [2:0]  op;
   logic        port_ok;
   logic [7:0]  tx_byte;

   // (R4) (R6) (R7) (R20) command fields, reserved bits unused
   assign op      = cmd_reg[0][2:0];
   assign port    = {cmd_reg[1][3:0], cmd_reg[2][7]};
   assign be      = cmd_reg[2][5:2];
   assign dw_addr = {cmd_reg[2][1:0], cmd_reg[3]};
   // (R5) only ports 0..5 are mapped
   assign port_ok = (port < `ICRP_NPORT);
   // (R13) byte 3 of the buffer leaves first
   assign tx_byte = rbuf_reg[{~idx_reg, 3'b000} +: 8];

   assign scl_rise  = scl_s2 && !scl_d;
   assign scl_fall  = !scl_s2 && scl_d;
   // (R1) start and stop seen while clock is high
   assign start_det = scl_s2 && scl_d && !sda_s2 && sda_d;
   assign stop_det  = scl_s2 && scl_d && sda_s2 && !sda_d;
   assign bus.sda_d_o = 1'b0;

   // link pin synchronisers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= bus.scl;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   // (R1) slave address from straps, resynchronised on every clock
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         strap_s1 <= 3'h0;
         strap_s2 <= 3'h0;
         slv_reg  <= {`ICRP_SLV_HI, 3'h0};
      end else begin
         strap_s1 <= addr_strap;
         strap_s2 <= strap_s1;
         slv_reg  <= {`ICRP_SLV_HI, strap_s2};
      end
   end

   // serial protocol engine
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         phase_reg       <= icrp_pkg::PH_IDLE;
         cnt_reg         <= 4'h0;
         idx_reg         <= 2'h0;
         sh_reg          <= 8'h00;
         wfull_reg       <= 1'b0;
         wdata_reg       <= 32'h0000_0000;
         fetch_pend_reg  <= 1'b0;
         commit_pend_reg <= 1'b0;
         bus.sda_d_oe_n  <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            cmd_reg[i] <= 8'h00;
         end
      end else begin
         fetch_pend_reg  <= 1'b0;
         commit_pend_reg <= 1'b0;
         if (start_det) begin
            // (R15) repeated start restarts at the address byte
            phase_reg      <= icrp_pkg::PH_ADDR;
            cnt_reg        <= 4'h0;
            wfull_reg      <= 1'b0;
            bus.sda_d_oe_n <= 1'b1;
         end else if (stop_det) begin
            phase_reg      <= icrp_pkg::PH_IDLE;
            cnt_reg        <= 4'h0;
            bus.sda_d_oe_n <= 1'b1;
         end else if (scl_rise && phase_reg != icrp_pkg::PH_IDLE) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg != `ICRP_BIT_ACK) begin
               sh_reg <= {sh_reg[6:0], sda_s2};
            end else if (phase_reg == icrp_pkg::PH_TX && sda_s2) begin
               phase_reg <= icrp_pkg::PH_SKIP;
            end
         end else if (scl_fall && phase_reg != icrp_pkg::PH_IDLE) begin
            if (cnt_reg == `ICRP_BIT_ACK) begin
               bus.sda_d_oe_n <= 1'b1;
               case (phase_reg)
                  icrp_pkg::PH_ADDR: begin
                     // (R20) foreign address is left unanswered
                     if (sh_reg[7:1] == slv_reg) begin
                        // (R19) acknowledge own address
                        bus.sda_d_oe_n <= 1'b0;
                        idx_reg        <= 2'h0;
                        // (R11) (R10) read bit selects transmit
                        phase_reg      <= sh_reg[0] ? icrp_pkg::PH_TX
                                                    : icrp_pkg::PH_CMD;
                     end else begin
                        phase_reg <= icrp_pkg::PH_SKIP;
                     end
                  end
                  icrp_pkg::PH_CMD: begin
                     // (R19) (R9) acknowledge each command byte
                     bus.sda_d_oe_n   <= 1'b0;
                     cmd_reg[idx_reg] <= sh_reg;
                     idx_reg          <= idx_reg + 2'h1;
                     if (idx_reg == `ICRP_LAST_IDX) begin
                        phase_reg <= icrp_pkg::PH_WDAT;
                        // (R3) (R12) read command fetches register
                        fetch_pend_reg <= (op == `ICRP_OP_RD);
                     end
                  end
                  icrp_pkg::PH_WDAT: begin
                     // (R16) (R18) (R17) only four bytes of a valid write
                     if (op == `ICRP_OP_WR && !wfull_reg) begin
                        bus.sda_d_oe_n <= 1'b0;
                        // (R8) first data byte lands in byte 3
                        wdata_reg      <= {wdata_reg[23:0], sh_reg};
                        idx_reg        <= idx_reg + 2'h1;
                        if (idx_reg == `ICRP_LAST_IDX) begin
                           wfull_reg       <= 1'b1;
                           commit_pend_reg <= 1'b1;
                        end
                     end
                  end
                  icrp_pkg::PH_TX: begin
                     // (R14) index wraps back to byte 3
                     idx_reg <= idx_reg + 2'h1;
                  end
                  default: bus.sda_d_oe_n <= 1'b1;
               endcase
            end else if (cnt_reg == `ICRP_BIT_END) begin
               cnt_reg        <= 4'h0;
               bus.sda_d_oe_n <= (phase_reg == icrp_pkg::PH_TX) ? tx_byte[7] : 1'b1;
            end else if (phase_reg == icrp_pkg::PH_TX) begin
               bus.sda_d_oe_n <= tx_byte[3'h7 - cnt_reg[2:0]];
            end
         end
      end
   end

   // register space: commit of a serial write, then local loads
   always_ff @(posedge sys_clk) begin
      if (commit_pend_reg && port_ok) begin
         // (R6) (R19) enabled bytes written after fourth byte
         for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
               mem[port[2:0]][dw_addr][8*i +: 8] <= wdata_reg[8*i +: 8];
            end
         end
      end else if (load_stb && load_port < 3'(`ICRP_NPORT)) begin
         mem[load_port][load_addr] <= load_data;
      end
   end

   // (R12) holding buffer, unmapped ports read zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rbuf_reg <= 32'h0000_0000;
      end else if (fetch_pend_reg) begin
         rbuf_reg <= port_ok ? mem[port[2:0]][dw_addr] : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         peek_data <= 32'h0000_0000;
         upd_stb   <= 1'b0;
         upd_port  <= 5'h00;
         upd_addr  <= 10'h000;
      end else begin
         peek_data <= (peek_port < 3'(`ICRP_NPORT)) ? mem[peek_port][peek_addr]
                                                     : 32'h0000_0000;
         upd_stb   <= commit_pend_reg && port_ok;
         if (commit_pend_reg) begin
            upd_port <= port;
            upd_addr <= dw_addr;
         end
      end
   end
endmodule : icrp_dev
`default_nettype wire

// *** icrp_link_props.sv ***
// link-level assertions for the two-wire register port
`timescale 1ns/1ps
`default_nettype none
module icrp_link_props (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic scl_h_o,
   input wire logic scl_h_oe_n,
   input wire logic sda_h_o,
   input wire logic sda_h_oe_n,
   input wire logic sda_d_o,
   input wire logic sda_d_oe_n,
   input wire logic scl,
   input wire logic sda
);
   logic [3:0] nbit_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // bits clocked since the last start
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         nbit_reg <= 4'h0;
      end else if (scl && $fell(sda)) begin
         nbit_reg <= 4'h0;
      end else if ($rose(scl) && nbit_reg != 4'hf) begin
         nbit_reg <= nbit_reg + 4'h1;
      end
   end
   sequence s_start;
      scl && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $rose(sda);
   endsequence
   property p_drive_low;
      !scl_h_o && !sda_h_o && !sda_d_o;
   endproperty
   property p_scl_high;
      $rose(scl) |-> scl [*8];
   endproperty
   property p_scl_low;
      $fell(scl) |-> !scl [*8];
   endproperty
   property p_start;
      s_start |-> sda_d_oe_n ##[1:16] !scl;
   endproperty
   property p_stop;
      s_stop |-> (scl && sda) [*8];
   endproperty
   property p_dev_steady;
      scl && $past(scl) |-> $stable(sda_d_oe_n);
   endproperty
   property p_one_drv;
      $rose(scl) |-> sda_h_oe_n || sda_d_oe_n;
   endproperty
   property p_addr_quiet;
      $rose(scl) && nbit_reg < 4'h8 |-> sda_d_oe_n;
   endproperty
   property p_pull_hold;
      $fell(sda_d_oe_n) |-> !sda_d_oe_n [*8];
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("open-drain level high");
   a_scl_high: assert property (p_scl_high) else $error("clock high too short");
   a_scl_low: assert property (p_scl_low) else $error("clock low too short");
   a_start: assert property (p_start) else $error("bad start framing");
   a_stop: assert property (p_stop) else $error("bad stop framing");
   a_dev_steady: assert property (p_dev_steady) else $error("data moved in clock high");
   a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
   a_addr_quiet: assert property (p_addr_quiet) else $error("device drove address");
   a_pull_hold: assert property (p_pull_hold) else $error("device pull too short");
endmodule : icrp_link_props
`default_nettype wire

// *** i2c_config_register_port_tb.sv ***
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module i2c_config_register_port_tb;
   typedef struct packed { logic nk; logic rc; logic [31:0] rv; } icrp_note_t;
   logic        sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, rd = 1'b0, merged = 1'b0;
   logic        load_stb = 1'b0, busy, done, nack_err, upd_stb;
   logic [2:0]  dev_strap = 3'h0, addr_strap = 3'h0, opcode = 3'h0;
   logic [2:0]  load_port = 3'h0, peek_port = 3'h0;
   logic [4:0]  port_sel = 5'h00, upd_port, p;
   logic [9:0]  dw_addr = 10'h000, load_addr = 10'h000, peek_addr = 10'h000, upd_addr, a;
   logic [3:0]  byte_en = 4'h0, be;
   logic [31:0] wdata = 32'h0, load_data = 32'h0, rdata, peek_data, d, old, ev, v;
   icrp_note_t  notes[$], cur;
   int          failures = 0, cmp_count = 0, upd_n = 0, exp_upd = 0, seed = 62522;
   icrp_if lnk ();
   icrp_host i_icrp_host (.sys_clk(sys_clk), .nrst(nrst), .bus(lnk), .dev_strap(dev_strap),
      .go(go), .rd(rd), .merged(merged), .opcode(opcode), .port_sel(port_sel),
      .dw_addr(dw_addr), .byte_en(byte_en), .wdata(wdata), .busy(busy), .done(done),
      .nack_err(nack_err), .rdata(rdata));
   icrp_dev i_icrp_dev (.sys_clk(sys_clk), .nrst(nrst), .bus(lnk), .addr_strap(addr_strap),
      .load_stb(load_stb), .load_port(load_port), .load_addr(load_addr),
      .load_data(load_data), .peek_port(peek_port), .peek_addr(peek_addr),
      .peek_data(peek_data), .upd_stb(upd_stb), .upd_port(upd_port), .upd_addr(upd_addr));
   icrp_link_props i_icrp_link_props (.sys_clk(sys_clk), .nrst(nrst), .scl_h_o(lnk.scl_h_o),
      .scl_h_oe_n(lnk.scl_h_oe_n), .sda_h_o(lnk.sda_h_o), .sda_h_oe_n(lnk.sda_h_oe_n),
      .sda_d_o(lnk.sda_d_o), .sda_d_oe_n(lnk.sda_d_oe_n), .scl(lnk.scl), .sda(lnk.sda));
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   // one host transfer; the expected outcome is noted first
   task automatic xfer(logic r, logic m, logic [2:0] op, logic [4:0] pp, logic [9:0] aa,
                       logic [3:0] bb, logic [31:0] dd, logic nk, logic [31:0] rv);
      notes.push_back('{nk, r & ~nk, rv});
      @(posedge sys_clk);
      go <= 1'b1;
      rd <= r;
      merged <= m;
      opcode <= op;
      port_sel <= pp;
      dw_addr <= aa;
      byte_en <= bb;
      wdata <= dd;
      @(posedge sys_clk);
      go <= 1'b0;
      for (int i = 0; i < 6000 && done !== 1'b1; i++) begin
         @(posedge sys_clk);
      end
      if (done !== 1'b1) begin
         failures++;
         test_done();
      end
      @(posedge sys_clk);
   endtask : xfer
   task automatic load(logic [2:0] pp, logic [9:0] aa, logic [31:0] dd);
      @(posedge sys_clk);
      load_stb <= 1'b1;
      load_port <= pp;
      load_addr <= aa;
      load_data <= dd;
      @(posedge sys_clk);
      load_stb <= 1'b0;
   endtask : load
   task automatic peek(logic [2:0] pp, logic [9:0] aa);
      @(posedge sys_clk);
      peek_port <= pp;
      peek_addr <= aa;
      repeat (2) @(posedge sys_clk);
      v = peek_data;
   endtask : peek
   // result watcher takes the oldest note at each done
   always @(posedge sys_clk) begin
      if (done === 1'b1) begin
         if (notes.size() == 0) begin
            chk("note queue", 32'h1, 32'h0);
         end else begin
            cur = notes.pop_front();
            chk("nack_err", {31'h0, cur.nk}, {31'h0, nack_err});
            chk("busy", 32'h0, {31'h0, busy});
            if (cur.rc) chk("rdata", cur.rv, rdata);
         end
      end
      if (upd_stb === 1'b1) upd_n++;
   end
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      failures++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      load(3'h0, 10'h03e, 32'hffffffff);
      xfer(1'b0, 1'b0, 3'h3, 5'h00, 10'h03e, 4'hf, 32'h12345678, 1'b0, 32'h0);
      exp_upd++;
      peek(3'h0, 10'h03e);
      chk("stored", 32'h12345678, v);
      for (int m = 0; m < 2; m++) begin
         xfer(1'b1, m[0], 3'h4, 5'h00, 10'h03e, 4'hf, 32'h0, 1'b0, 32'h12345678);
      end
      for (int k = 0; k < 4; k++) begin
         p = 5'({$random(seed)} % 6);
         a = 10'($random(seed));
         be = 4'($random(seed));
         d = $random(seed);
         old = $random(seed);
         load(p[2:0], a, old);
         for (int b = 0; b < 4; b++) ev[8*b +: 8] = be[b] ? d[8*b +: 8] : old[8*b +: 8];
         xfer(1'b0, 1'b0, 3'h3, p, a, be, d, 1'b0, 32'h0);
         exp_upd++;
         chk("upd target", {17'h0, p, a}, {17'h0, upd_port, upd_addr});
         xfer(1'b1, k[0], 3'h4, p, a, 4'hf, 32'h0, 1'b0, ev);
      end
      xfer(1'b0, 1'b0, 3'h3, 5'h06, 10'h011, 4'hf, 32'ha5a5a5a5, 1'b0, 32'h0);
      xfer(1'b1, 1'b1, 3'h4, 5'h1f, 10'h011, 4'hf, 32'h0, 1'b0, 32'h0);
      load(3'h2, 10'h155, 32'hcafe0001);
      for (int op = 0; op < 8; op++) begin
         if (op != 3 && op != 4) xfer(1'b0, 1'b0, op[2:0], 5'h02, 10'h155, 4'hf, 32'h0, 1'b1, 32'h0);
      end
      peek(3'h2, 10'h155);
      chk("unchanged", 32'hcafe0001, v);
      dev_strap <= 3'h1;
      xfer(1'b0, 1'b0, 3'h3, 5'h02, 10'h155, 4'hf, 32'h0, 1'b1, 32'h0);
      addr_strap <= 3'h5;
      dev_strap <= 3'h5;
      repeat (8) @(posedge sys_clk);
      xfer(1'b0, 1'b0, 3'h3, 5'h05, 10'h3ff, 4'hf, 32'h89abcdef, 1'b0, 32'h0);
      exp_upd++;
      xfer(1'b1, 1'b1, 3'h4, 5'h05, 10'h3ff, 4'hf, 32'h0, 1'b0, 32'h89abcdef);
      chk("commits", 32'(exp_upd), 32'(upd_n));
      test_done();
   end
endmodule : i2c_config_register_port_tb
`default_nettype wire
